// File: common/rrso_pkg.sv
// package of constants and carriers for the return, rotate and sleep executor
package rrso_pkg;
    localparam int RRSO_DATA_W = 8;
    localparam int RRSO_ADDR_W = 7;
    localparam int RRSO_PC_W = 15;
    localparam int RRSO_DEPTH = 16;
    localparam int RRSO_SP_W = 4;
    localparam int RRSO_WDT_W = 16;
    localparam int RRSO_PRE_W = 8;
    localparam logic [RRSO_DATA_W-1:0] RRSO_W_RESET = 8'h00;
    localparam logic [RRSO_PC_W-1:0] RRSO_PC_RESET = 15'h0000;
    localparam logic [RRSO_SP_W-1:0] RRSO_SP_RESET = 4'h0;
    localparam logic [RRSO_WDT_W-1:0] RRSO_WDT_CLEAR = 16'h0000;
    localparam logic [RRSO_PRE_W-1:0] RRSO_PRE_CLEAR = 8'h00;
    localparam logic [RRSO_PRE_W-1:0] RRSO_PRE_LIMIT = 8'hFF;
    localparam logic RRSO_DEST_W = 1'b0;
    localparam logic RRSO_DEST_F = 1'b1;

    // operation selector given by the outer decoder
    typedef enum logic [2:0] {
        RRSO_OP_NONE = 3'b000,
        RRSO_OP_RETLIT = 3'b001,
        RRSO_OP_RETURN = 3'b010,
        RRSO_OP_ROTL = 3'b011,
        RRSO_OP_ROTR = 3'b100,
        RRSO_OP_SLEEP = 3'b101
    } rrso_op_type;

    // one decoded instruction
    typedef struct packed {
        rrso_op_type op;
        logic [RRSO_DATA_W-1:0] literal;
        logic [RRSO_ADDR_W-1:0] file_addr;
        logic dest;
    } rrso_instr_type;

    // write request toward the data file
    typedef struct packed {
        logic we;
        logic [RRSO_ADDR_W-1:0] addr;
        logic [RRSO_DATA_W-1:0] data;
    } rrso_fwrite_type;
endpackage

// File: rtl/rrso_watchdog.sv
// watchdog counter with prescaler and a synchronous clear
`timescale 1ns/10ps
`default_nettype none
module rrso_watchdog #(
    parameter int PRE_W = rrso_pkg::RRSO_PRE_W,
    parameter int CNT_W = rrso_pkg::RRSO_WDT_W
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clear,
    output logic [CNT_W-1:0] count,
    output logic [PRE_W-1:0] prescale
);
    wire tick = (prescale == rrso_pkg::RRSO_PRE_LIMIT[PRE_W-1:0]);

    // prescaler gives a one-cycle tick enable; clear wins over counting
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || clear)
        begin
            prescale <= rrso_pkg::RRSO_PRE_CLEAR[PRE_W-1:0];
            count <= rrso_pkg::RRSO_WDT_CLEAR[CNT_W-1:0];
        end
        else
        begin
            prescale <= prescale + 1'b1;
            if (tick)
                count <= count + 1'b1;
        end
    end
endmodule // rrso_watchdog
`default_nettype wire

// File: rtl/rrso_core.sv
// executor for return-with-literal, return, rotates through carry and sleep
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module rrso_core #(
    parameter int DEPTH = rrso_pkg::RRSO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic instr_valid,
    input wire rrso_pkg::rrso_instr_type instr,
    input wire logic push_en,
    input wire logic [rrso_pkg::RRSO_PC_W-1:0] push_addr,
    input wire logic [rrso_pkg::RRSO_DATA_W-1:0] file_rdata,
    input wire logic wake,
    output logic instr_ready,
    output logic [rrso_pkg::RRSO_DATA_W-1:0] working_reg,
    output logic [rrso_pkg::RRSO_PC_W-1:0] program_counter,
    output logic pc_load,
    output rrso_pkg::rrso_fwrite_type file_wr,
    output logic carry_flag,
    output logic powerdown_flag_n,
    output logic timeout_flag_n,
    output logic asleep,
    output logic [rrso_pkg::RRSO_SP_W-1:0] stack_ptr,
    output logic [rrso_pkg::RRSO_WDT_W-1:0] watchdog_counter,
    output logic [rrso_pkg::RRSO_PRE_W-1:0] watchdog_prescale
);
    ////////////////////////////////////////////////////////////////////////
    // state
    typedef enum logic [1:0] {
        RRSO_ST_RUN = 2'b00,
        RRSO_ST_RET2 = 2'b01,
        RRSO_ST_SLEEP = 2'b10
    } rrso_state_type;

    rrso_state_type state;
    rrso_state_type next_state;
    logic [rrso_pkg::RRSO_PC_W-1:0] stack_mem [DEPTH];
    logic wdt_clear;

    ////////////////////////////////////////////////////////////////////////
    // decode
    // an instruction is only decoded in the run state, so a refused one has no effect
    wire run = (state == RRSO_ST_RUN) && instr_valid;
    wire is_retlit = run && (instr.op == rrso_pkg::RRSO_OP_RETLIT);
    wire is_return = run && (instr.op == rrso_pkg::RRSO_OP_RETURN);
    wire is_rotl = run && (instr.op == rrso_pkg::RRSO_OP_ROTL);
    wire is_rotr = run && (instr.op == rrso_pkg::RRSO_OP_ROTR);
    wire is_sleep = run && (instr.op == rrso_pkg::RRSO_OP_SLEEP);
    wire is_pop = is_retlit || is_return;
    wire is_rot = is_rotl || is_rotr;
    // top entry sits one below the pointer; pointer names the next free slot
    wire [rrso_pkg::RRSO_SP_W-1:0] top_idx = stack_ptr - 1'b1;
    wire [rrso_pkg::RRSO_PC_W-1:0] top_entry = stack_mem[top_idx];
    wire [rrso_pkg::RRSO_DATA_W-1:0] rotl_val = {file_rdata[6:0], carry_flag};
    wire rotl_c = file_rdata[7];
    wire [rrso_pkg::RRSO_DATA_W-1:0] rotr_val = {carry_flag, file_rdata[7:1]};
    wire rotr_c = file_rdata[0];
    // both rotates share one result path; the select follows the opcode
    wire [rrso_pkg::RRSO_DATA_W-1:0] rot_val = is_rotl ? rotl_val : rotr_val;
    wire rot_c = is_rotl ? rotl_c : rotr_c;
    wire rot_to_w = is_rot && (instr.dest == rrso_pkg::RRSO_DEST_W);
    wire rot_to_f = is_rot && (instr.dest == rrso_pkg::RRSO_DEST_F);

    ////////////////////////////////////////////////////////////////////////
    // next state: returns take a second cycle, sleep halts until wake
    // returns spend their second cycle in the return state so that fetch slot is refused
    always_comb
    begin
        next_state = state;
        case (state)
            RRSO_ST_RUN:
            begin
                if (is_pop)
                    next_state = RRSO_ST_RET2;
                else if (is_sleep)
                    next_state = RRSO_ST_SLEEP;
            end
            RRSO_ST_RET2:
                next_state = RRSO_ST_RUN;
            RRSO_ST_SLEEP:
                if (wake)
                    next_state = RRSO_ST_RUN;
            // unused codes fall back to run so the machine cannot lock up
            default:
                next_state = RRSO_ST_RUN;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            state <= RRSO_ST_RUN;
        else
            state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////////
    // return stack; a push from the call path is ignored during a pop
    // pointer wraps at the depth; an empty-stack pop is not guarded, callers keep balance
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            stack_ptr <= rrso_pkg::RRSO_SP_RESET;
        else if (is_pop)
            stack_ptr <= top_idx;
        else if (push_en && state == RRSO_ST_RUN)
            stack_ptr <= stack_ptr + 1'b1;
    end

    // no reset on the array: entries are only read after a push
    always_ff @(posedge sys_clk)
    begin
        if (push_en && state == RRSO_ST_RUN && !is_pop)
            stack_mem[stack_ptr] <= push_addr;
    end

    ////////////////////////////////////////////////////////////////////////
    // program counter load; pc_load marks the fresh value for one cycle
    // program_counter holds the last popped address until the next pop
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            program_counter <= rrso_pkg::RRSO_PC_RESET;
            pc_load <= 1'b0;
        end
        else
        begin
            pc_load <= 1'b0;
            if (is_pop)
            begin
                program_counter <= top_entry;
                pc_load <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // working register, carry and file write-back
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            working_reg <= rrso_pkg::RRSO_W_RESET;
            carry_flag <= 1'b0;
            file_wr <= '0;
        end
        else
        begin
            // address and data are registered every cycle; only we qualifies them
            file_wr.we <= rot_to_f;
            file_wr.addr <= instr.file_addr;
            file_wr.data <= rot_val;
            if (is_retlit)
                working_reg <= instr.literal;
            else if (rot_to_w)
                working_reg <= rot_val;
            // carry changes only on a rotate
            if (is_rot)
                carry_flag <= rot_c;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sleep flags; both read high after reset as after power-up
    // sleep clears powerdown_flag_n and holds timeout_flag_n high; only reset sets powerdown_flag_n high again
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            powerdown_flag_n <= 1'b1;
            timeout_flag_n <= 1'b1;
            asleep <= 1'b0;
        end
        else
        begin
            if (is_sleep)
            begin
                powerdown_flag_n <= 1'b0;
                timeout_flag_n <= 1'b1;
            end
            asleep <= (next_state == RRSO_ST_SLEEP);
        end
    end

    // ready reflects next cycle's ability to accept
    // taken from next_state so the output stays a flop yet tracks the state
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            instr_ready <= 1'b1;
        else
            instr_ready <= (next_state == RRSO_ST_RUN);
    end

    ////////////////////////////////////////////////////////////////////////
    // sleep clears watchdog and prescaler
    // clear lands in the sleep cycle itself so the count restarts from zero at once
    assign wdt_clear = is_sleep;

    rrso_watchdog #(
        .PRE_W(rrso_pkg::RRSO_PRE_W),
        .CNT_W(rrso_pkg::RRSO_WDT_W)
    ) u_wdt (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clear(wdt_clear),
        .count(watchdog_counter),
        .prescale(watchdog_prescale)
    );
endmodule // rrso_core
`default_nettype wire

// File: tb/rrso_core_checker.sv
// concurrent checks on the ports of the return, rotate and sleep executor
`timescale 1ns/10ps
`default_nettype none
module rrso_checker (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic instr_valid,
    input wire rrso_pkg::rrso_instr_type instr,
    input wire logic [7:0] file_rdata,
    input wire logic wake,
    input wire logic instr_ready,
    input wire logic [7:0] working_reg,
    input wire logic pc_load,
    input wire rrso_pkg::rrso_fwrite_type file_wr,
    input wire logic carry_flag,
    input wire logic powerdown_flag_n,
    input wire logic timeout_flag_n,
    input wire logic asleep,
    input wire logic [3:0] stack_ptr,
    input wire logic [15:0] watchdog_counter,
    input wire logic [7:0] watchdog_prescale
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    // an instruction counts only when the core was ready for it
    wire logic take = instr_valid && instr_ready;
    sequence s_ret;
        take && instr.op inside {rrso_pkg::RRSO_OP_RETURN, rrso_pkg::RRSO_OP_RETLIT};
    endsequence
    a_retlit_value: assert property (take && instr.op == rrso_pkg::RRSO_OP_RETLIT |=>
        working_reg == $past(instr.literal) && pc_load) else $error("literal not in wreg");
    a_ret_two_cycles: assert property (s_ret |=> !instr_ready ##1 instr_ready)
        else $error("return not two cycles");
    a_ret_pop: assert property (s_ret |=> stack_ptr == $past(stack_ptr) - 4'h1 && pc_load)
        else $error("pop did not step pointer");
    a_ret_flags: assert property (s_ret |=> carry_flag == $past(carry_flag)
        && powerdown_flag_n == $past(powerdown_flag_n)) else $error("return changed flags");
    a_rotl_file: assert property (take && instr.op == rrso_pkg::RRSO_OP_ROTL && instr.dest |=>
        file_wr.we && file_wr.data == {$past(file_rdata[6:0]), $past(carry_flag)}
        && carry_flag == $past(file_rdata[7])) else $error("rotate left wrong");
    a_rotr_wreg: assert property (take && instr.op == rrso_pkg::RRSO_OP_ROTR && !instr.dest |=>
        !file_wr.we && working_reg == {$past(carry_flag), $past(file_rdata[7:1])}
        && carry_flag == $past(file_rdata[0])) else $error("rotate right wrong");
    a_sleep_clear: assert property (take && instr.op == rrso_pkg::RRSO_OP_SLEEP |=>
        watchdog_counter == 16'h0000 && watchdog_prescale == 8'h00
        && !powerdown_flag_n && timeout_flag_n && asleep) else $error("sleep entry wrong");
    a_sleep_halt: assert property (asleep && !wake |=> asleep && !instr_ready)
        else $error("core ran while asleep");
endmodule // rrso_checker
bind rrso_core rrso_checker rrso_checker_inst (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .instr_valid(instr_valid),
    .instr(instr),
    .file_rdata(file_rdata),
    .wake(wake),
    .instr_ready(instr_ready),
    .working_reg(working_reg),
    .pc_load(pc_load),
    .file_wr(file_wr),
    .carry_flag(carry_flag),
    .powerdown_flag_n(powerdown_flag_n),
    .timeout_flag_n(timeout_flag_n),
    .asleep(asleep),
    .stack_ptr(stack_ptr),
    .watchdog_counter(watchdog_counter),
    .watchdog_prescale(watchdog_prescale)
);
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the return, rotate and sleep executor
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic instr_valid = 1'b0;
    rrso_pkg::rrso_instr_type instr = '0;
    logic push_en = 1'b0;
    logic [14:0] push_addr = 15'h0000;
    logic [7:0] file_rdata = 8'h00;
    logic wake = 1'b0;
    logic instr_ready, pc_load, carry_flag, powerdown_flag_n, timeout_flag_n, asleep;
    logic [7:0] working_reg;
    logic [7:0] watchdog_prescale;
    logic [14:0] program_counter;
    logic [3:0] stack_ptr;
    logic [15:0] watchdog_counter;
    rrso_pkg::rrso_fwrite_type file_wr;
    logic [14:0] stk [16];
    logic [3:0] e_sp = 4'h0;
    logic e_c = 1'b0;
    logic [6:0] e_fa = 7'h00;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    rrso_core rrso_core_inst (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .instr_valid(instr_valid),
        .instr(instr),
        .push_en(push_en),
        .push_addr(push_addr),
        .file_rdata(file_rdata),
        .wake(wake),
        .instr_ready(instr_ready),
        .working_reg(working_reg),
        .program_counter(program_counter),
        .pc_load(pc_load),
        .file_wr(file_wr),
        .carry_flag(carry_flag),
        .powerdown_flag_n(powerdown_flag_n),
        .timeout_flag_n(timeout_flag_n),
        .asleep(asleep),
        .stack_ptr(stack_ptr),
        .watchdog_counter(watchdog_counter),
        .watchdog_prescale(watchdog_prescale)
    );
    ////////////////////////////////////////////////////////////////
    // 50 ns clock and a hang guard far beyond the few hundred cycles used
    initial forever #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({15'h0000, got}, {15'h0000, exp});
    endtask
    // one instruction held for one cycle; checks land at the following falling edge
    task automatic issue(input rrso_pkg::rrso_op_type op, input logic [7:0] k,
        input logic d, input logic [7:0] rd);
        @(posedge sys_clk);
        e_fa = 7'($urandom);
        instr_valid <= 1'b1;
        instr <= '{op, k, e_fa, d};
        file_rdata <= rd;
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        @(negedge sys_clk);
    endtask
    // expected {carry, result} of a rotate through carry
    function automatic logic [8:0] rot(input logic left, input logic c, input logic [7:0] v);
        return left ? {v, c} : {v[0], c, v[7:1]};
    endfunction
    ////////////////////////////////////////////////////////////////
    initial
    begin
        logic [8:0] r;
        logic [7:0] v;
        logic [14:0] a;
        void'($urandom(11432));
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        // rotates in both directions and both destinations, edge bits first
        for (int i = 0; i < 24; i++)
        begin
            v = (i < 4) ? (i[0] ? 8'h80 : 8'h01) : 8'($urandom);
            r = rot(i[0], e_c, v);
            issue(i[0] ? rrso_pkg::RRSO_OP_ROTL : rrso_pkg::RRSO_OP_ROTR, 8'h00, i[1], v);
            e_c = r[8];
            chk_bit(carry_flag, e_c);
            chk_bit(file_wr.we, i[1]);
            chk_val(16'(i[1] ? file_wr.data : working_reg), 16'(r[7:0]));
            chk_val(16'(file_wr.addr), 16'(e_fa));
        end
        $display("test rotate done");
        // push six random addresses onto the return stack
        for (int i = 0; i < 6; i++)
        begin
            a = 15'($urandom);
            @(posedge sys_clk);
            push_en <= 1'b1;
            push_addr <= a;
            stk[e_sp] = a;
            e_sp++;
            @(posedge sys_clk);
            push_en <= 1'b0;
        end
        // alternate literal returns and plain returns, literal extremes first
        for (int i = 0; i < 6; i++)
        begin
            v = (i == 0) ? 8'hFF : (i == 2) ? 8'h00 : 8'($urandom);
            e_sp--;
            issue(i[0] ? rrso_pkg::RRSO_OP_RETURN : rrso_pkg::RRSO_OP_RETLIT, v, 1'b0, 8'h00);
            chk_val(16'(program_counter), 16'(stk[e_sp]));
            chk_bit(pc_load, 1'b1);
            chk_val(16'(stack_ptr), 16'(e_sp));
            chk_bit(instr_ready, 1'b0);
            chk_bit(carry_flag, e_c);
            if (!i[0])
                chk_val(16'(working_reg), 16'(v));
        end
        $display("test return done");
        // let the watchdog advance past one prescaler period so the clear can be seen
        repeat (300) @(negedge sys_clk);
        chk_bit(watchdog_counter != 16'h0000, 1'b1);
        issue(rrso_pkg::RRSO_OP_SLEEP, 8'h00, 1'b0, 8'h00);
        chk_val(watchdog_counter, 16'h0000);
        chk_val(16'(watchdog_prescale), 16'h0000);
        chk_bit(powerdown_flag_n, 1'b0);
        chk_bit(timeout_flag_n, 1'b1);
        chk_bit(carry_flag, e_c);
        // a rotate offered while asleep must be refused
        // its top bit is the inverse of carry, so a wrongly taken rotate would flip it
        issue(rrso_pkg::RRSO_OP_ROTL, 8'h00, 1'b0, e_c ? 8'h00 : 8'hFF);
        chk_bit(asleep, 1'b1);
        chk_bit(carry_flag, e_c);
        chk_bit(watchdog_prescale != 8'h00, 1'b1);
        @(posedge sys_clk);
        wake <= 1'b1;
        @(posedge sys_clk);
        wake <= 1'b0;
        @(negedge sys_clk);
        chk_bit(asleep, 1'b0);
        chk_bit(instr_ready, 1'b1);
        $display("test sleep done");
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
